// ===== bench/adc_channel_sequencer_tb.sv
// self-checking bench for the channel sequencer
// assumes the host model drives the link and a 12-bit result
`timescale 1ns/1ps
module adc_channel_sequencer_tb;
  import adc_seq_pkg::*;
  logic ref_clk, rst_b, sclk, cs_b, din, dout, comp_in, result_valid, cod, pend;
  front_t front;
  result_t result;
  logic [11:0] vin [8];
  logic [15:0] last, lf;
  seq_mode_t lmode;
  logic [2:0] ms [7] = '{3'h1, 3'h3, 3'h4, 3'h6, 3'h0, 3'h7, 3'h1};
  int bad_count = 0, compares = 0, cycles = 0, k;
  adc_channel_sequencer #(.RES_BITS(12)) u_adc_channel_sequencer (.ref_clk(ref_clk),
    .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout), .comp_in(comp_in),
    .front(front), .result_valid(result_valid), .result(result));
  adc_host_model u_adc_host_model (.sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout),
    .comp_in(comp_in), .dac_code(front.dac_code), .mux_sel(front.mux_sel), .vin(vin));
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard and capture of the system-side word
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (result_valid === 1'h1) begin
      last <= result.word;
      lmode <= result.mode;
    end
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // next value of the bench's random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // zero, channel, code with its msb flipped for twos complement
  function automatic logic [15:0] exp_word(input logic [2:0] ch, input logic [11:0] v,
                                           input logic c);
    return {1'h0, ch, v ^ {~c, 11'h000}};
  endfunction
  function automatic logic [15:0] cw(input logic q, s, input logic [2:0] a, input logic g);
    return {1'h1, q, 1'h0, a, 2'h3, s, 1'h0, g, 1'h1, 4'h0};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one frame: word seen on dout and on the system side
  task automatic step(input logic [15:0] w, input logic [2:0] ch);
    logic [15:0] r, e;
    e = exp_word(ch, vin[ch], cod);
    u_adc_host_model.frame(w, r);
    check("dout word", e, r);
    repeat (8) @(posedge ref_clk);
    check("result word", e, last);
    if (!pend && w[15]) cod = w[4];
    pend = !pend && w[15:14] == 2'h2 && w[7];
    #2;
    for (int i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      vin[i] = lf[11:0];
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'h0;
    cod = 1'h0;
    pend = 1'h0;
    lf = 16'h0037;
    for (k = 0; k < 8; k++) vin[k] = {1'h1, 3'(k), 8'h5a};
    repeat (4) @(posedge ref_clk);
    #2 rst_b = 1'h1;
    repeat (2) @(posedge ref_clk);
    for (k = 0; k < 9; k++) step(cw(0, 0, 3'(k), 0), k ? 3'(k - 1) : 3'h0);
    step(cw(0, 0, 6, 0), 3'h0);
    step(16'h0000, 3'h6);
    step(cw(0, 1, 2, 0), 3'h6);
    step(16'h5a81, 3'h2);
    for (k = 0; k < 7; k++) step(16'h0000, ms[k]);
    check("span x2", 16'h0001, 16'(front.span_x2));
    check("seq mode", 16'(SEQ_MASKED), 16'(lmode));
    check("coding", 16'(cod), 16'(front.straight_binary));
    check("power mode", 16'h0003, 16'(front.power_mode));
    step(cw(1, 0, 5, 1), 3'h3);
    check("span x1", 16'h0000, 16'(front.span_x2));
    step(cw(0, 0, 2, 1), 3'h4);
    step(16'h0000, 3'h2);
    step(cw(1, 1, 3, 1), 3'h2);
    step(16'h0000, 3'h0);
    step(16'h0000, 3'h1);
    step(cw(1, 0, 0, 1), 3'h2);
    step(16'h0000, 3'h3);
    step(cw(0, 0, 7, 1), 3'h0);
    step(16'h0000, 3'h7);
    finish_test();
  end
endmodule // adc_channel_sequencer_tb

// ===== bench/adc_host_model.sv
// serial host and analog source facing the sequencer
// assumes the bench calls frame() one at a time
`timescale 1ns/1ps
module adc_host_model (
  output logic sclk,
  output logic cs_b,
  output logic din,
  input wire logic dout,
  output logic comp_in,
  input wire logic [11:0] dac_code,
  input wire logic [2:0] mux_sel,
  input wire logic [11:0] vin [8]
);
  logic [2:0] ch_q;
  initial begin
    sclk = 1'h1;
    cs_b = 1'h1;
    din = 1'h0;
    ch_q = 3'h0;
  end
  // held sample: mux moves at edge 14 while bits still resolve
  assign comp_in = vin[ch_q] >= dac_code;
  // 125 ns sclk, idle edge with cs high first, then 16 edges
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    #62.5 sclk = 1'h0;
    #62.5 sclk = 1'h1;
    cs_b = 1'h0;
    ch_q = mux_sel;
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      #62.5 r[i] = dout;
      sclk = 1'h0;
      #62.5 sclk = 1'h1;
    end
    cs_b = 1'h1;
    din = ~din; // released line must not echo the last bit
  endtask
endmodule // adc_host_model

// ===== bench/adc_seq_sva.sv
// checker on the channel sequencer ports
// assumes sclk stands still outside frames and reset comes once at start
`timescale 1ns/1ps
module adc_seq_sva #(
  parameter int RES_BITS = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic dout,
  input wire adc_seq_pkg::front_t front,
  input wire logic result_valid,
  input wire adc_seq_pkg::result_t result
);
  import adc_seq_pkg::*;
  logic [4:0] n_q;
  logic [2:0] ch_q;
  // armed after the first edge, so change checks have a real past value
  logic armed_q;
  // edge count within a frame, channel seen at its first edge
  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      n_q <= 5'h00;
      ch_q <= 3'h0;
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
      n_q <= cs_b ? 5'h00 : (n_q == EDGE_LAST ? n_q : n_q + 5'h01);
      if (n_q == 5'h00) ch_q <= front.mux_sel;
    end
  end
  mux_step_a: assert property (@(negedge sclk) disable iff (!rst_b)
    armed_q && $changed(front.mux_sel) |-> n_q == EDGE_MUX || n_q == EDGE_LAST)
    else $error("mux step");
  ctl_apply_a: assert property (@(negedge sclk) disable iff (!rst_b)
    armed_q && $changed({front.span_x2, front.power_mode}) |-> n_q == EDGE_MUX)
    else $error("ctl apply");
  hold_on_a: assert property (@(negedge sclk) disable iff (!rst_b)
    !cs_b |=> front.sample_hold) else $error("hold");
  lead_zero_a: assert property (@(negedge sclk) disable iff (!rst_b)
    n_q == 5'h00 && !cs_b |-> !dout) else $error("lead zero");
  addr_out_a: assert property (@(negedge sclk) disable iff (!rst_b)
    n_q == 5'h01 |-> dout == ch_q[2] ##1 dout == ch_q[1] ##1 dout == ch_q[0]) else $error("addr");
  tail_zero_a: assert property (@(negedge sclk) disable iff (!rst_b)
    n_q == EDGE_LAST |-> !dout) else $error("tail zero");
  valid_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    result_valid |=> !result_valid) else $error("valid pulse");
  word_lead_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    result_valid |-> !result.word[15] && result.mode != 2'h3) else $error("word lead");
endmodule // adc_seq_sva
bind adc_channel_sequencer adc_seq_sva #(.RES_BITS(RES_BITS)) u_adc_seq_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .dout(dout),
  .front(front), .result_valid(result_valid), .result(result));

// ===== core/adc_channel_sequencer.sv
// serial control, sequencer and successive-approximation logic of the converter
// assumes the host keeps sclk running for 16 falling edges per chip-select frame
// and that comp_in settles within one sclk period of each dac_code change
`timescale 1ns/1ps

module adc_channel_sequencer #(
  parameter int RES_BITS = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic din,
  output logic dout,
  input wire logic comp_in,
  output adc_seq_pkg::front_t front,
  output logic result_valid,
  output adc_seq_pkg::result_t result
);
  import adc_seq_pkg::*;

  localparam logic [4:0] EDGE_DATA_LAST = 5'(int'(EDGE_DATA_FIRST) + RES_BITS - 1);

  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] shift;
    logic range_b;
    logic coding_b;
    logic [1:0] pm;
    logic seq_bit;
    logic shadow_bit;
    logic [15:0] mask;
    logic mask_pend;
    seq_mode_t mode;
    logic [2:0] last_ch;
    logic [3:0] pos;
    logic [2:0] mux;
    logic [2:0] conv;
    logic [11:0] sar;
    logic [11:0] probe;
    logic dout;
    logic sample;
    result_t hold;
    logic tgl;
    logic mask_now; // this frame carries the mask word
    logic flip; // twos complement setting of this conversion
  } link_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic seen;
    logic valid;
    result_t res;
  } sys_state_t;

  // power-up: manual mode, nothing pending, mask cleared, mux on channel 0
  localparam link_state_t LINK_RESET = '{
    cnt: 5'h00,
    shift: 16'h0000,
    range_b: RANGE_RESET,
    coding_b: CODING_RESET,
    pm: PM_RESET,
    seq_bit: 1'b0,
    shadow_bit: 1'b0,
    mask: MASK_RESET,
    mask_pend: 1'b0,
    mode: SEQ_MANUAL,
    last_ch: 3'h0,
    pos: POS_BEFORE_FIRST,
    mux: 3'h0,
    conv: 3'h0,
    sar: 12'h000,
    probe: 12'h000,
    dout: 1'b0,
    sample: 1'b0,
    hold: '{word: 16'h0000, mode: SEQ_MANUAL},
    tgl: 1'b0,
    mask_now: 1'b0,
    flip: 1'b0
  };

  // system side idles with no word taken yet
  localparam sys_state_t SYS_RESET = '{
    sync1: 1'b0,
    sync2: 1'b0,
    seen: 1'b0,
    valid: 1'b0,
    res: '{word: 16'h0000, mode: SEQ_MANUAL}
  };

  // channel address field of a control word
  function automatic logic [2:0] addr_of(input logic [CTRL_W-1:0] c);
    return c[CTRL_ADDR_HI:CTRL_ADDR_LO];
  endfunction

  // next channel of a consecutive run, back to 0 after the last one
  function automatic logic [2:0] next_consec(input logic [2:0] cur, input logic [2:0] last);
    return (cur == last) ? 3'h0 : cur + 3'h1;
  endfunction

  // next enabled mask slot after cur, wrapping; slot p tests bit 15-p
  function automatic logic [3:0] next_pos(input logic [15:0] m, input logic [3:0] cur);
    logic [3:0] p;
    logic found;
    logic [3:0] r;
    found = 1'b0;
    r = cur;
    for (int i = 1; i <= WORD_W; i++) begin
      p = cur + 4'(i);
      if (!found && m[4'hf - p]) begin
        found = 1'b1;
        r = p;
      end
    end
    return r;
  endfunction

  // registered state and its next value, one pair per clock domain
  link_state_t lq, ld;
  sys_state_t sq, sd;

  // link side: everything here runs on sclk falling edges, inside a frame or with cs_b high
  always_comb begin
    logic [4:0] n;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] word;
    logic [3:0] adv_pos;
    logic [2:0] adv_mux;
    logic bit_dec;
    // edge number this fall makes, control bits as shifted so far
    n = lq.cnt + 5'h01;
    ctrl = lq.shift[CTRL_W:1];
    word = {lq.shift[14:0], din};
    bit_dec = comp_in;
    // hold everything unless an edge below says otherwise
    ld = lq;
    // one step of whichever sequence is running
    adv_pos = lq.pos;
    adv_mux = lq.mux;
    if (lq.mode == SEQ_CONSEC) begin
      adv_mux = next_consec(lq.mux, lq.last_ch);
    end else if (lq.mode == SEQ_MASKED) begin
      adv_pos = next_pos(lq.mask, lq.pos);
      adv_mux = adv_pos[2:0];
    end
    if (cs_b) begin
      // frame over; next low edge starts a fresh one
      ld.cnt = 5'h00;
      ld.sample = 1'b0;
      ld.dout = 1'b0;
    end else if (lq.cnt != EDGE_LAST) begin
      ld.cnt = n;
      ld.shift = word;
      // leading zero already out, then channel address of this conversion
      if (n == EDGE_ADDR_FIRST) begin
        ld.conv = lq.mux;
        ld.dout = lq.mux[2];
        ld.sample = 1'b1;
        // frozen here, so a write at edge 14 only affects the next frame
        ld.flip = !lq.coding_b;
        ld.mask_now = lq.mask_pend;
      end
      if (n == EDGE_ADDR_MID) begin
        ld.dout = lq.conv[1];
      end
      if (n == EDGE_ADDR_LAST) begin
        ld.dout = lq.conv[0];
        ld.sar = 12'h000;
        ld.probe = SAR_FIRST_PROBE;
      end
      // one decision per edge, msb first; sclk is the conversion clock
      if (n >= EDGE_DATA_FIRST) begin
        if (n <= EDGE_DATA_LAST) begin
          if (bit_dec) begin
            ld.sar = lq.sar | lq.probe;
          end
          ld.probe = lq.probe >> 1;
          // twos complement is offset binary with the msb flipped
          ld.dout = bit_dec ^ ((n == EDGE_DATA_FIRST) && lq.flip);
        end else begin
          ld.dout = 1'b0;
        end
      end
      // control word is whole by now; mask frames wait for their last edge
      if (n == EDGE_MUX && !lq.mask_now) begin
        if (ctrl[CTRL_WRITE]) begin
          ld.range_b = ctrl[CTRL_RANGE];
          ld.coding_b = ctrl[CTRL_CODING];
          ld.pm = ctrl[CTRL_PM_HI:CTRL_PM_LO];
          ld.seq_bit = ctrl[CTRL_SEQ];
          ld.shadow_bit = ctrl[CTRL_SHADOW];
          // the sequence bit pattern decides the fate of a running sequence
          unique case ({ctrl[CTRL_SEQ], ctrl[CTRL_SHADOW]})
            2'b00: begin
              ld.mode = SEQ_MANUAL;
              ld.mux = addr_of(ctrl);
            end
            2'b01: begin
              ld.mode = SEQ_MANUAL;
              ld.mask_pend = 1'b1;
              ld.mux = addr_of(ctrl);
            end
            2'b10: begin
              if (lq.mode == SEQ_MANUAL) begin
                ld.mux = addr_of(ctrl);
              end else begin
                ld.pos = adv_pos;
                ld.mux = adv_mux;
              end
            end
            2'b11: begin
              ld.mode = SEQ_CONSEC;
              ld.last_ch = addr_of(ctrl);
              ld.mux = 3'h0;
            end
          endcase
        end else begin
          ld.pos = adv_pos;
          ld.mux = adv_mux;
        end
      end
      // last edge: mask lands if this frame carries it, result word goes across
      if (n == EDGE_LAST) begin
        if (lq.mask_now) begin
          // previous write asked for it, so this word is the mask
          ld.mask = word;
          ld.mask_pend = 1'b0;
          ld.mask_now = 1'b0;
          ld.mode = SEQ_MASKED;
          ld.pos = next_pos(word, POS_BEFORE_FIRST);
          ld.mux = ld.pos[2:0];
        end
        ld.hold.word = {1'b0, lq.conv, lq.sar ^ (lq.flip ? TWOS_FLIP : 12'h000)};
        ld.hold.mode = lq.mode;
        ld.tgl = !lq.tgl;
      end
    end
  end

  // sclk domain; clock may stop between frames, nothing waits on it there
  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      lq <= LINK_RESET;
    end else begin
      lq <= ld;
    end
  end

  // system side: toggle crosses through two flops, word is stable by then
  always_comb begin
    sd = sq;
    sd.sync1 = lq.tgl;
    sd.sync2 = sq.sync1;
    sd.seen = sq.sync2;
    sd.valid = sq.sync2 ^ sq.seen;
    // word is taken only on the pulse and held until the next one
    if (sq.sync2 ^ sq.seen) begin
      sd.res = lq.hold;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sq <= SYS_RESET;
    end else begin
      sq <= sd;
    end
  end

  // outputs straight from flops, span_x2 inverted, dac code an or of two
  assign dout = lq.dout;
  assign front.mux_sel = lq.mux;
  assign front.dac_code = lq.sar | lq.probe;
  assign front.span_x2 = !lq.range_b;
  assign front.straight_binary = lq.coding_b;
  assign front.power_mode = lq.pm;
  assign front.sample_hold = lq.sample;
  assign result_valid = sq.valid;
  assign result = sq.res;
endmodule // adc_channel_sequencer

// ===== core/adc_seq_pkg.sv
// constants, field layout and carrier types for the channel sequencer
// assumes one 16-bit serial frame per conversion, framed by the chip select
package adc_seq_pkg;
  // control word layout, bit 11 is the first bit shifted in
  localparam int CTRL_W = 12;
  localparam int CTRL_WRITE = 11;
  localparam int CTRL_SEQ = 10;
  localparam int CTRL_ADDR_HI = 8;
  localparam int CTRL_ADDR_LO = 6;
  localparam int CTRL_PM_HI = 5;
  localparam int CTRL_PM_LO = 4;
  localparam int CTRL_SHADOW = 3;
  localparam int CTRL_RANGE = 1;
  localparam int CTRL_CODING = 0;
  // frame geometry in serial clock falling edges
  localparam int WORD_W = 16;
  localparam int MAX_RES = 12;
  localparam logic [4:0] EDGE_ADDR_FIRST = 5'h01;
  localparam logic [4:0] EDGE_ADDR_MID = 5'h02;
  localparam logic [4:0] EDGE_ADDR_LAST = 5'h03;
  localparam logic [4:0] EDGE_DATA_FIRST = 5'h04;
  localparam logic [4:0] EDGE_MUX = 5'h0e;
  localparam logic [4:0] EDGE_LAST = 5'h10;
  localparam logic [11:0] SAR_FIRST_PROBE = 12'h800;
  localparam logic [11:0] TWOS_FLIP = 12'h800;
  // reset values
  localparam logic [1:0] PM_RESET = 2'h3;
  localparam logic RANGE_RESET = 1'b0;
  localparam logic CODING_RESET = 1'b0;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [3:0] POS_BEFORE_FIRST = 4'hf;

  typedef enum logic [1:0] {
    SEQ_MANUAL = 2'b00,
    SEQ_MASKED = 2'b01,
    SEQ_CONSEC = 2'b10
  } seq_mode_t;

  // one finished conversion as handed to the system side
  typedef struct packed {
    logic [15:0] word;
    seq_mode_t mode;
  } result_t;

  // analog front end controls
  typedef struct packed {
    logic [2:0] mux_sel;
    logic [11:0] dac_code;
    logic span_x2;
    logic straight_binary;
    logic [1:0] power_mode;
    logic sample_hold;
  } front_t;
endpackage
